// ---- dfl_fault_latch.sv ----
// Fault latch and clear logic of a servo drive, with AHB-Lite registers.
// Assumes fault inputs are asynchronous pins; one clock hclk at 20 MHz.
`timescale 1ns/1ps

module dfl_fault_latch
  import dfl_pkg::*;
#(
  parameter int NPAIRS = 3
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [NPAIRS-1:0] enc1_p,
  input  wire logic [NPAIRS-1:0] enc1_n,
  input  wire logic [NPAIRS-1:0] enc2_p,
  input  wire logic [NPAIRS-1:0] enc2_n,
  input  wire logic              param_calc_fault,
  input  wire logic              drive_mode_fault,
  input  wire logic              run_error,
  input  wire logic              power_stage_fault_interrupt,
  input  wire logic              pulse_count_fault,
  input  wire logic              amplitude_fault,
  input  wire logic              abs_if_fitted,
  input  wire logic              reinit_on_clear,
  output logic                   motor_output_on,
  output logic                   drive_ready,
  output logic                   emergency_closed,
  output logic                   enc1_ok,
  output logic                   enc2_ok
);

  // Synchronise all pin inputs (two flops)
  localparam int NSYNC = 4 * NPAIRS + 8;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {enc1_p, enc1_n, enc2_p, enc2_n, param_calc_fault, drive_mode_fault, run_error,
                    power_stage_fault_interrupt, pulse_count_fault, amplitude_fault,
                    abs_if_fitted, reinit_on_clear};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else if (clk_en)
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic [NPAIRS-1:0] s_e1p, s_e1n, s_e2p, s_e2n;
  logic s_param, s_mode, s_run, s_pwr, s_pulse, s_ampl, s_abs, s_reinit;
  assign {s_e1p, s_e1n, s_e2p, s_e2n, s_param, s_mode, s_run, s_pwr, s_pulse, s_ampl,
          s_abs, s_reinit} = sync2_reg;

  // Antivalence check per pair
  logic [NPAIRS-1:0] av1;
  logic [NPAIRS-1:0] av2;
  genvar gi;
  generate
    for (gi = 0; gi < NPAIRS; gi++)
    begin : g_av
      assign av1[gi] = s_e1p[gi] ^ s_e1n[gi];
      assign av2[gi] = s_e2p[gi] ^ s_e2n[gi];
    end
  endgenerate
  assign enc1_ok = &av1;
  assign enc2_ok = &av2;

  dfl_state_t st_reg;
  dfl_state_t st_next;

  // Bus and clear decode
  logic        wr_act;
  logic        enc1_trip, enc2_trip;
  logic        clr_edge, cmd_clear, clear_ok;
  logic [DFL_NFLAGS-1:0] set_vec;
  logic [31:0] status_word, error_word;

  assign enc1_trip = (st_reg.enc_cnt1 >= st_reg.enc_thr);
  assign enc2_trip = (st_reg.enc_cnt2 >= st_reg.enc_thr);
  assign wr_act    = st_reg.ph_valid && st_reg.ph_write;
  assign clr_edge  = st_reg.ctrl[DFL_CW_CLEAR_BIT] && !st_reg.clr_prev;
  assign cmd_clear = wr_act && (st_reg.ph_addr == DFL_OFF_CMD) && (hwdata == DFL_CMD_CLEAR);
  assign clear_ok  = (clr_edge || cmd_clear) && !st_reg.ctrl[DFL_CW_ENABLE_BIT];

  // Fault causes; pulse and amplitude causes go to E01 when absolute interface fitted
  always_comb
  begin
    set_vec = '0;
    set_vec[DFL_F_PARAM]  = s_param;
    set_vec[DFL_F_MODE]   = s_mode;
    set_vec[DFL_F_RUN]    = s_run;
    set_vec[DFL_F_POWER]  = s_pwr;
    set_vec[DFL_F_ENC1]   = enc1_trip || (s_abs && (s_pulse || s_ampl));
    set_vec[DFL_F_ENC2]   = enc2_trip;
    set_vec[DFL_F_PULSES] = s_pulse && !s_abs;
    set_vec[DFL_F_AMPL]   = s_ampl && !s_abs;
  end

  // Words shown on the fieldbus
  always_comb
  begin
    status_word = '0;
    status_word[DFL_SW_READY_BIT]   = drive_ready;
    status_word[DFL_SW_CLEARED_BIT] = (st_reg.cleared_cnt != '0);
    status_word[DFL_SW_MODE_BIT]    = st_reg.flags[DFL_F_MODE];
    error_word = '0;
    error_word[DFL_EW_PARAM_BIT] = st_reg.flags[DFL_F_PARAM];
    error_word[DFL_EW_RUN_BIT]   = st_reg.flags[DFL_F_RUN];
    error_word[DFL_EW_POWER_BIT] = st_reg.flags[DFL_F_POWER];
    error_word[DFL_EW_ENC_BIT]   = |st_reg.flags[DFL_F_AMPL:DFL_F_ENC1];
  end

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    st_next.clr_prev = st_reg.ctrl[DFL_CW_CLEAR_BIT];
    // Encoder low-run counters, reset on any high sample
    if (enc1_ok)
      st_next.enc_cnt1 = '0;
    else if (!enc1_trip)
      st_next.enc_cnt1 = st_reg.enc_cnt1 + 16'h0001;
    if (enc2_ok)
      st_next.enc_cnt2 = '0;
    else if (!enc2_trip)
      st_next.enc_cnt2 = st_reg.enc_cnt2 + 16'h0001;
    // Clear deletable flags, then latch new causes; set wins
    if (clear_ok)
    begin
      st_next.flags = st_reg.flags & DFL_NONDEL_MASK;
      st_next.cleared_cnt = 8'(DFL_CLR_IND_CYC);
      st_next.reinit_msg = s_reinit;
    end
    else if (st_reg.cleared_cnt != '0)
      st_next.cleared_cnt = st_reg.cleared_cnt - 8'h01;
    st_next.flags = st_next.flags | set_vec;
    // Fault text, most severe cause first
    if (st_next.flags[DFL_F_POWER])
      st_next.text = DFL_TXT_E16;
    else if (st_next.flags[DFL_F_PARAM])
      st_next.text = DFL_TXT_E33;
    else if (st_next.flags[DFL_F_MODE])
      st_next.text = DFL_TXT_E34;
    else if (st_next.flags[DFL_F_ENC1])
      st_next.text = DFL_TXT_E01;
    else if (st_next.flags[DFL_F_ENC2])
      st_next.text = DFL_TXT_E02;
    else if (st_next.flags[DFL_F_PULSES])
      st_next.text = DFL_TXT_E03;
    else if (st_next.flags[DFL_F_AMPL])
      st_next.text = DFL_TXT_E04;
    else if (st_next.flags[DFL_F_RUN])
      st_next.text = DFL_TXT_E35;
    else if (st_next.reinit_msg)
      st_next.text = DFL_TXT_E36;
    else
      st_next.text = DFL_TXT_NONE;
    // Data-phase writes
    if (wr_act)
    begin
      case (st_reg.ph_addr)
        DFL_OFF_CTRL:    st_next.ctrl = hwdata;
        DFL_OFF_ENC_THR: st_next.enc_thr = hwdata[15:0];
        default:         ;
      endcase
    end
    // Address phase capture and read data
    st_next.ph_valid = hsel && hready && htrans[1];
    st_next.ph_write = hwrite;
    st_next.ph_addr  = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        DFL_OFF_CTRL:     st_next.rdata = st_reg.ctrl;
        DFL_OFF_STATUS:   st_next.rdata = status_word;
        DFL_OFF_ERROR:    st_next.rdata = error_word;
        DFL_OFF_FLAGS:    st_next.rdata = {24'h00_0000, st_reg.flags};
        DFL_OFF_FAULTTXT: st_next.rdata = {24'h00_0000, st_reg.text};
        DFL_OFF_ENC_THR:  st_next.rdata = {16'h0000, st_reg.enc_thr};
        default:          st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
      st_reg.enc_thr <= DFL_ENC_THR_RST;
    end
    else if (clk_en)
      st_reg <= st_next;
  end

  // Outputs: no motor voltage or readiness while any flag set
  assign drive_ready      = (st_reg.flags == '0);
  assign motor_output_on  = drive_ready && st_reg.ctrl[DFL_CW_ENABLE_BIT];
  assign emergency_closed = st_reg.flags[DFL_F_PARAM] || st_reg.flags[DFL_F_MODE];
  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Checks
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && st_reg.flags[DFL_F_PARAM] && !clear_ok |=> st_reg.flags[DFL_F_PARAM])
    else $error("param flag lost without clear");
  a_ready_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.flags != '0) |-> !drive_ready && !motor_output_on)
    else $error("ready while flag set");
  a_power_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && st_reg.flags[DFL_F_POWER] |=> st_reg.flags[DFL_F_POWER])
    else $error("power stage flag cleared");
  a_enabled_noclear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && st_reg.ctrl[DFL_CW_ENABLE_BIT] && !wr_act |=> st_reg.flags >= $past(st_reg.flags))
    else $error("flags changed while enabled");
  a_clear_reported: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && clear_ok |=> status_word[DFL_SW_CLEARED_BIT])
    else $error("clear not reported");
  a_enc_count_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && enc1_ok |=> st_reg.enc_cnt1 == '0)
    else $error("encoder counter not reset");
  a_param_error_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.flags[DFL_F_PARAM] |-> error_word[DFL_EW_PARAM_BIT] && emergency_closed)
    else $error("code 33 not reported");
  a_mode_status_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.flags[DFL_F_MODE] |-> status_word[DFL_SW_MODE_BIT] && !motor_output_on)
    else $error("code 34 not reported");

  // Step sequences: a deletion, a held clear bit, an encoder low run
  sequence s_quiet_clear;
    clk_en && clear_ok && (set_vec == '0);
  endsequence

  sequence s_clear_req;
    clk_en && clear_ok;
  endsequence

  sequence s_bit9_held;
    clk_en && st_reg.ctrl[DFL_CW_CLEAR_BIT] && st_reg.clr_prev && !cmd_clear;
  endsequence

  sequence s_enc1_run;
    clk_en && !enc1_ok && !enc1_trip;
  endsequence

  sequence s_enc1_full;
    clk_en && !enc1_ok && enc1_trip;
  endsequence

  sequence s_enc2_full;
    clk_en && !enc2_ok && enc2_trip;
  endsequence

  // Deletion keeps only restart-only flags
  a_clear_deletes: assert property (@(posedge hclk) disable iff (!hresetn)
    s_quiet_clear |=> st_reg.flags == ($past(st_reg.flags) & DFL_NONDEL_MASK))
    else $error("deletable flags kept after clear");

  // A clear bit that stays high acts only once
  a_edge_only: assert property (@(posedge hclk) disable iff (!hresetn)
    s_bit9_held |-> !clear_ok)
    else $error("clear acted on a held level");

  // Deletion raises the status pulse at full length
  a_cleared_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    s_clear_req |=> st_reg.cleared_cnt == 8'(DFL_CLR_IND_CYC))
    else $error("deletion pulse length wrong");

  // Every active cause lands in its flag; set wins
  a_set_latches: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && (set_vec != '0) |=> (st_reg.flags & $past(set_vec)) == $past(set_vec))
    else $error("fault cause not latched");

  // Motor voltage only with enable and no flag
  a_motor_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    motor_output_on |-> st_reg.ctrl[DFL_CW_ENABLE_BIT] && (st_reg.flags == '0))
    else $error("motor on with fault or no enable");

  // Run error has no emergency reaction of its own
  a_run_only: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.flags[DFL_F_RUN] && !st_reg.flags[DFL_F_PARAM] && !st_reg.flags[DFL_F_MODE]
      |-> error_word[DFL_EW_RUN_BIT] && !emergency_closed)
    else $error("run error reaction wrong");

  // Power stage fault shows in error word and text
  a_power_shown: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.flags[DFL_F_POWER] |-> error_word[DFL_EW_POWER_BIT] && (st_reg.text == DFL_TXT_E16))
    else $error("power stage fault not shown");

  // Any encoder flag shows in the error word
  a_enc_shown: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.flags[DFL_F_AMPL:DFL_F_ENC1] != '0) |-> error_word[DFL_EW_ENC_BIT])
    else $error("encoder fault not shown");

  // No flag and no message leaves the text empty
  a_text_empty: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.flags == '0) && !st_reg.reinit_msg |-> st_reg.text == DFL_TXT_NONE)
    else $error("fault text without fault");

  // Low run climbs by one per low sample
  a_enc_climb: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enc1_run |=> st_reg.enc_cnt1 == $past(st_reg.enc_cnt1) + 16'h0001)
    else $error("encoder low run miscounted");

  // Full low run raises the channel flag
  a_enc1_trip: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enc1_full |=> st_reg.flags[DFL_F_ENC1])
    else $error("channel 1 encoder fault missed");
  a_enc2_trip: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enc2_full |=> st_reg.flags[DFL_F_ENC2])
    else $error("channel 2 encoder fault missed");

  // Equal pair levels pull the check low
  a_pair_equal: assert property (@(posedge hclk) disable iff (!hresetn)
    (~(s_e1p ^ s_e1n) != '0) |-> !enc1_ok)
    else $error("equal pair not flagged");

  // Pulse and amplitude causes, routed by interface
  a_pulse_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_pulse && !s_abs |=> st_reg.flags[DFL_F_PULSES])
    else $error("pulse count fault missed");
  a_ampl_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_ampl && !s_abs |=> st_reg.flags[DFL_F_AMPL])
    else $error("amplitude fault missed");
  a_abs_route: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && s_abs && (s_pulse || s_ampl) |=> st_reg.flags[DFL_F_ENC1])
    else $error("absolute interface fault not on channel 1");

  // Bus slave never stalls and always answers OKAY
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not okay");

endmodule // dfl_fault_latch

// ---- dfl_pkg.sv ----
// Package for the drive fault latch block: register map, flag positions,
// reset values and timing counts.
// Assumes a 20 MHz hclk and a 32-bit AHB-Lite register bus.
package dfl_pkg;

  // Register byte offsets
  localparam logic [7:0] DFL_OFF_CTRL     = 8'h00; // Drive control word
  localparam logic [7:0] DFL_OFF_STATUS   = 8'h04; // Drive status word
  localparam logic [7:0] DFL_OFF_ERROR    = 8'h08; // Drive error word
  localparam logic [7:0] DFL_OFF_FLAGS    = 8'h0C; // Latched fault flags
  localparam logic [7:0] DFL_OFF_CMD      = 8'h10; // Fieldbus clear command
  localparam logic [7:0] DFL_OFF_FAULTTXT = 8'h14; // Fault text code
  localparam logic [7:0] DFL_OFF_ENC_THR  = 8'h18; // Encoder low-run threshold

  // Control word fields
  localparam int DFL_CW_ENABLE_BIT = 0;
  localparam int DFL_CW_CLEAR_BIT  = 9;
  // Status word fields
  localparam int DFL_SW_READY_BIT   = 0;
  localparam int DFL_SW_CLEARED_BIT = 4;
  localparam int DFL_SW_MODE_BIT    = 20;
  // Error word fields
  localparam int DFL_EW_PARAM_BIT = 3;
  localparam int DFL_EW_RUN_BIT   = 15;
  localparam int DFL_EW_POWER_BIT = 16;
  localparam int DFL_EW_ENC_BIT   = 1;

  // Latched flag positions
  localparam int DFL_F_PARAM  = 0; // Code 33
  localparam int DFL_F_MODE   = 1; // Code 34
  localparam int DFL_F_RUN    = 2; // Code 35
  localparam int DFL_F_POWER  = 3; // E16, restart only
  localparam int DFL_F_ENC1   = 4; // E01
  localparam int DFL_F_ENC2   = 5; // E02
  localparam int DFL_F_PULSES = 6; // E03
  localparam int DFL_F_AMPL   = 7; // E04
  localparam int DFL_NFLAGS   = 8;
  localparam logic [DFL_NFLAGS-1:0] DFL_NONDEL_MASK = 8'h08;

  // Fault text codes
  localparam logic [7:0] DFL_TXT_NONE = 8'h00;
  localparam logic [7:0] DFL_TXT_E01  = 8'h01;
  localparam logic [7:0] DFL_TXT_E02  = 8'h02;
  localparam logic [7:0] DFL_TXT_E03  = 8'h03;
  localparam logic [7:0] DFL_TXT_E04  = 8'h04;
  localparam logic [7:0] DFL_TXT_E16  = 8'h10;
  localparam logic [7:0] DFL_TXT_E33  = 8'h21;
  localparam logic [7:0] DFL_TXT_E34  = 8'h22;
  localparam logic [7:0] DFL_TXT_E35  = 8'h23;
  localparam logic [7:0] DFL_TXT_E36  = 8'h24;

  // Clear command value on the command register
  localparam logic [31:0] DFL_CMD_CLEAR = 32'h0000_0099;

  // Encoder low-run threshold after reset, in samples
  localparam logic [15:0] DFL_ENC_THR_RST = 16'h0010;

  // Status bit 4 pulse length
  localparam int DFL_CLR_IND_NS  = 1000;
  localparam int DFL_CLK_NS      = 50;
  localparam int DFL_CLR_IND_CYC = DFL_CLR_IND_NS / DFL_CLK_NS;

  typedef struct packed {
    logic [31:0] ctrl;
    logic        clr_prev;
    logic [DFL_NFLAGS-1:0] flags;
    logic [7:0]  text;
    logic [15:0] enc_thr;
    logic [15:0] enc_cnt1;
    logic [15:0] enc_cnt2;
    logic [7:0]  cleared_cnt;
    logic        reinit_msg;
    logic        ph_valid;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
  } dfl_state_t;

endpackage

// ---- dfl_enc_model.sv ----
// Encoder model: drives complementary signal pairs from a running count.
// Assumes hclk from the bench; a break input makes pair 0 of a channel equal.
`timescale 1ns/1ps
module dfl_enc_model #(
  parameter int NPAIRS = 3
)(
  input  wire logic              hclk,
  input  wire logic              brk1,
  input  wire logic              brk2,
  output logic      [NPAIRS-1:0] enc1_p,
  output logic      [NPAIRS-1:0] enc1_n,
  output logic      [NPAIRS-1:0] enc2_p,
  output logic      [NPAIRS-1:0] enc2_n
);
  logic [NPAIRS-1:0] cnt_reg = '0;

  // Running pattern keeps every line moving
  always_ff @(posedge hclk)
    cnt_reg <= cnt_reg + 1'b1;

  // Pairs differ unless a break is commanded
  assign enc1_p = cnt_reg;
  assign enc1_n = ~cnt_reg ^ {{(NPAIRS-1){1'b0}}, brk1};
  assign enc2_p = ~cnt_reg;
  assign enc2_n = cnt_reg ^ {{(NPAIRS-1){1'b0}}, brk2};
endmodule // dfl_enc_model

// ---- tb.sv ----
// Self-checking bench for the drive fault latch block.
// Assumes the block's own assertions; bench acts as AHB-Lite master.
`timescale 1ns/1ps
module tb;
  import dfl_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, enc1_p, enc1_n, enc2_p, enc2_n;
  logic        f33, f34, f35, f16, f03, f04, abs_fit, reinit, brk1, brk2;
  logic        motor_on, ready, emerg, ok1, ok2;
  int          failures, n_compared;

  // Clock at 20 MHz
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  dfl_enc_model #(.NPAIRS(3)) enc (.hclk(hclk), .brk1(brk1), .brk2(brk2),
    .enc1_p(enc1_p), .enc1_n(enc1_n), .enc2_p(enc2_p), .enc2_n(enc2_n));

  dfl_fault_latch #(.NPAIRS(3)) dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .enc1_p(enc1_p), .enc1_n(enc1_n), .enc2_p(enc2_p), .enc2_n(enc2_n),
    .param_calc_fault(f33), .drive_mode_fault(f34), .run_error(f35),
    .power_stage_fault_interrupt(f16), .pulse_count_fault(f03), .amplitude_fault(f04),
    .abs_if_fitted(abs_fit), .reinit_on_clear(reinit), .motor_output_on(motor_on),
    .drive_ready(ready), .emergency_closed(emerg), .enc1_ok(ok1), .enc2_ok(ok2));

  // Verdict and end of run
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Bounded wait for hready sampled high
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      failures++;
      end_sim();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= 32'(a);
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    check(nm, exp, rd);
  endtask

  task automatic t_reset();
    check("drive_ready", 1'b1, ready);
    check("hresp", 32'h0000_0000, 32'(hresp));
    check("hreadyout", 32'h0000_0001, 32'(hreadyout));
    rchk(DFL_OFF_ENC_THR, 32'(DFL_ENC_THR_RST), "enc_thr");
    rchk(8'h1C, 32'h0000_0000, "unmapped");
    xfer(1'b1, DFL_OFF_CTRL, 32'h0000_0001);
    tick(1);
    check("motor_on", 1'b1, motor_on);
    $display("test reset done");
  endtask

  task automatic t_param();
    f33 <= 1'b1;
    f34 <= 1'b1;
    tick(4);
    f33 <= 1'b0;
    f34 <= 1'b0;
    tick(6);
    check("motor_on", 1'b0, motor_on);
    check("drive_ready", 1'b0, ready);
    check("emergency", 1'b1, emerg);
    rchk(DFL_OFF_FLAGS, 32'h0000_0003, "flags");
    rchk(DFL_OFF_ERROR, 32'h0000_0008, "error_word");
    rchk(DFL_OFF_STATUS, 32'h0010_0000, "status_word");
    $display("test param done");
  endtask

  task automatic t_clear();
    xfer(1'b1, DFL_OFF_CTRL, 32'h0000_0201);
    tick(2);
    rchk(DFL_OFF_FLAGS, 32'h0000_0003, "flags");
    reinit <= 1'b1;
    xfer(1'b1, DFL_OFF_CTRL, 32'h0000_0000);
    xfer(1'b1, DFL_OFF_CTRL, 32'h0000_0200);
    tick(2);
    rchk(DFL_OFF_FLAGS, 32'h0000_0000, "flags");
    rchk(DFL_OFF_STATUS, 32'h0000_0011, "status_word");
    rchk(DFL_OFF_FAULTTXT, 32'(DFL_TXT_E36), "fault_text");
    check("drive_ready", 1'b1, ready);
    reinit <= 1'b0;
    $display("test clear done");
  endtask

  task automatic t_power();
    f16 <= 1'b1;
    tick(4);
    f16 <= 1'b0;
    tick(6);
    rchk(DFL_OFF_FAULTTXT, 32'(DFL_TXT_E16), "fault_text");
    f35 <= 1'b1;
    tick(4);
    f35 <= 1'b0;
    tick(6);
    check("emergency", 1'b0, emerg);
    rchk(DFL_OFF_ERROR, 32'h0001_8000, "error_word");
    rchk(DFL_OFF_FLAGS, 32'h0000_000C, "flags");
    xfer(1'b1, DFL_OFF_CMD, DFL_CMD_CLEAR);
    tick(2);
    rchk(DFL_OFF_FLAGS, 32'h0000_0008, "flags");
    check("drive_ready", 1'b0, ready);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    rchk(DFL_OFF_FLAGS, 32'h0000_0000, "flags");
    $display("test power done");
  endtask

  // One encoder fault cause, then a command clear
  task automatic cause(input logic a, input logic p, input logic m, input logic [31:0] exp);
    abs_fit <= a;
    f03     <= p;
    f04     <= m;
    tick(4);
    f03 <= 1'b0;
    f04 <= 1'b0;
    tick(6);
    rchk(DFL_OFF_FLAGS, exp, "flags");
    xfer(1'b1, DFL_OFF_CMD, DFL_CMD_CLEAR);
    tick(3);
  endtask

  task automatic t_enc();
    xfer(1'b1, DFL_OFF_ENC_THR, 32'h0000_0006);
    brk1 <= 1'b1;
    tick(4);
    check("enc1_ok", 1'b0, ok1);
    check("enc2_ok", 1'b1, ok2);
    brk1 <= 1'b0;
    tick(6);
    rchk(DFL_OFF_FLAGS, 32'h0000_0000, "flags");
    brk2 <= 1'b1;
    tick(12);
    brk2 <= 1'b0;
    tick(4);
    rchk(DFL_OFF_FLAGS, 32'h0000_0020, "flags");
    rchk(DFL_OFF_ERROR, 32'h0000_0002, "error_word");
    xfer(1'b1, DFL_OFF_CMD, DFL_CMD_CLEAR);
    tick(3);
    cause(1'b0, 1'b1, 1'b0, 32'h0000_0040);
    cause(1'b0, 1'b0, 1'b1, 32'h0000_0080);
    cause(1'b1, 1'b0, 1'b1, 32'h0000_0010);
    $display("test encoder done");
  endtask

  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, f33, f34, f35, f16, f03, f04, abs_fit, reinit, brk1, brk2} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_param();
    t_clear();
    t_power();
    t_enc();
    end_sim();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    end_sim();
  end
endmodule // tb
